// ---- hw/rbs_map.svh ----
`ifndef RBS_MAP_SVH
`define RBS_MAP_SVH

// register offsets
`define GEN_HW_STATUS_OFS 32'hFFBC015F
`define VALID_STATUS_OFS 32'hFFBC0160
`define OUTPUT_BYTE_OFS 32'hFFBC0161
`define IRQ_STATUS_OFS 32'hFFBC0162
`define IRQ_MASK_OFS 32'hFFBC0163

// field positions
`define HW_ENABLE_BIT 0
`define HW_PRESENT_BIT 6
`define VALID_BIT 0
`define IRQ_BYTE_BIT 0

// reset values
`define GEN_HW_STATUS_RST 8'h40
`define VALID_STATUS_RST 8'h00
`define OUTPUT_BYTE_RST 8'h40

// timing
`define BYTE_BITS 8

`endif

// ---- hw/rbs_pkg.sv ----
package rbs_pkg;
    typedef enum logic [2:0] {
        ST_SLEEP = 3'h1,
        ST_FILL = 3'h2,
        ST_FULL = 3'h4
    } gen_state_t;
endpackage

// ---- hw/noise_if.sv ----
`timescale 1ns/1ps
interface noise_if;
    logic run;
    logic bit_valid;
    logic bit_val;
    modport src (input run, output bit_valid, output bit_val);
    modport sink (output run, input bit_valid, input bit_val);
endinterface

// ---- hw/noise_bit_source.sv ----
`timescale 1ns/1ps
module noise_bit_source #(
    parameter int LFSR_W = 16
) (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // bits out
    noise_if.src nz
);
    typedef struct packed {
        logic [LFSR_W-1:0] lfsr;
        logic bit_valid;
    } src_state_t;
    src_state_t s_r;
    src_state_t s_nxt;

    initial begin
        if (LFSR_W != 16) begin
            $error("noise_bit_source only supports LFSR_W of 16");
        end
    end

    // stand-in for the analogue noise; frozen while not running to save power
    always_comb begin
        s_nxt = s_r;
        s_nxt.bit_valid = 1'b0;
        if (nz.run) begin
            s_nxt.lfsr = {s_r.lfsr[LFSR_W-2:0], s_r.lfsr[15] ^ s_r.lfsr[13] ^ s_r.lfsr[12] ^ s_r.lfsr[10]};
            s_nxt.bit_valid = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s_r <= '{lfsr: 16'hACE1, bit_valid: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign nz.bit_valid = s_r.bit_valid;
    assign nz.bit_val = s_r.lfsr[0];
endmodule

// ---- hw/rd_data_reg.sv ----
`timescale 1ns/1ps
module rd_data_reg #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    initial begin
        if (W < 1) begin
            $error("rd_data_reg width must be positive");
        end
    end

    // registered read data, one cycle behind the strobe
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule

// ---- hw/hw_random_byte_source.sv ----
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`include "rbs_map.svh"
module hw_random_byte_source
    import rbs_pkg::*;
#(
    parameter logic GEN_PRESENT = 1'b1,
    parameter int AW = 32
) (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // register port
    input wire logic [AW-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // interrupt
    output logic irq
);
    typedef struct packed {
        gen_state_t st;
        logic enable;
        logic valid;
        logic [7:0] shift;
        logic [2:0] cnt;
        logic [7:0] out_byte;
        logic irq_stat;
        logic irq_mask;
    } top_state_t;

    top_state_t s_r;
    top_state_t s_nxt;
    logic [7:0] rd_mux;
    logic present;
    logic rd_data_hit;
    logic byte_done;

    noise_if nz();

    initial begin
        if (AW < 32) begin
            $error("address width must be at least 32");
        end
    end

    assign present = GEN_PRESENT;
    assign rd_data_hit = rd && (addr == `OUTPUT_BYTE_OFS);
    // a bit still in flight when enable drops must not complete a byte
    assign byte_done = nz.bit_valid && s_r.enable && (s_r.st == ST_FILL) && (s_r.cnt == 3'h7);

    // noise source only runs while collecting; it idles otherwise to save power
    assign nz.run = s_r.enable && present && (s_r.st == ST_FILL);

    noise_bit_source #(.LFSR_W(16)) u_src (
        .mclk(mclk),
        .nrst(nrst),
        .nz(nz.src)
    );

    // next state of the whole block
    always_comb begin
        s_nxt = s_r;
        if (wr && addr == `GEN_HW_STATUS_OFS) begin
            s_nxt.enable = wdata[`HW_ENABLE_BIT];
        end
        if (wr && addr == `IRQ_MASK_OFS) begin
            s_nxt.irq_mask = wdata[`IRQ_BYTE_BIT];
        end
        case (s_r.st)
            ST_SLEEP: begin
                if (s_r.enable && present) begin
                    s_nxt.st = ST_FILL;
                    s_nxt.cnt = 3'h0;
                end
            end
            ST_FILL: begin
                if (!s_r.enable) begin
                    s_nxt.st = ST_SLEEP;
                end else if (nz.bit_valid) begin
                    s_nxt.shift = {s_r.shift[6:0], nz.bit_val};
                    s_nxt.cnt = s_r.cnt + 3'h1;
                    if (byte_done) begin
                        s_nxt.out_byte = {s_r.shift[6:0], nz.bit_val};
                        s_nxt.st = ST_FULL;
                    end
                end
            end
            ST_FULL: begin
                // wait for the byte to be taken before collecting another
                if (rd_data_hit) begin
                    s_nxt.st = s_r.enable ? ST_FILL : ST_SLEEP;
                    s_nxt.cnt = 3'h0;
                end
            end
            default: s_nxt.st = ST_SLEEP;
        endcase
        // a byte landing wins over a read in the same cycle
        if (byte_done) begin
            s_nxt.valid = 1'b1;
        end else if (rd_data_hit) begin
            s_nxt.valid = 1'b0;
        end
        // set wins over write-one-to-clear
        if (byte_done) begin
            s_nxt.irq_stat = 1'b1;
        end else if (wr && addr == `IRQ_STATUS_OFS && wdata[`IRQ_BYTE_BIT]) begin
            s_nxt.irq_stat = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s_r.st <= ST_SLEEP;
            s_r.enable <= 1'b0;
            s_r.valid <= 1'b0;
            s_r.shift <= 8'h00;
            s_r.cnt <= 3'h0;
            s_r.out_byte <= `OUTPUT_BYTE_RST;
            s_r.irq_stat <= 1'b0;
            s_r.irq_mask <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // read decode; reserved bits and unmapped addresses read zero
    always_comb begin
        rd_mux = 8'h00;
        if (rd) begin
            case (addr)
                `GEN_HW_STATUS_OFS: begin
                    rd_mux[`HW_PRESENT_BIT] = present;
                    rd_mux[`HW_ENABLE_BIT] = s_r.enable;
                end
                `VALID_STATUS_OFS: rd_mux[`VALID_BIT] = s_r.valid;
                `OUTPUT_BYTE_OFS: rd_mux = s_r.out_byte;
                `IRQ_STATUS_OFS: rd_mux[`IRQ_BYTE_BIT] = s_r.irq_stat;
                `IRQ_MASK_OFS: rd_mux[`IRQ_BYTE_BIT] = s_r.irq_mask;
                default: rd_mux = 8'h00;
            endcase
        end
    end

    rd_data_reg #(.W(8)) u_rd (
        .mclk(mclk),
        .nrst(nrst),
        .d(rd_mux),
        .q(rdata)
    );

    assign irq = s_r.irq_stat & s_r.irq_mask;

    // checks
    valid_set_a: assert property (@(posedge mclk) disable iff (!nrst)
        byte_done |=> s_r.valid) else $error("valid not set after full byte");
    valid_clear_a: assert property (@(posedge mclk) disable iff (!nrst)
        (rd_data_hit && !byte_done) |=> !s_r.valid) else $error("valid not cleared by read");
    no_shift_off_a: assert property (@(posedge mclk) disable iff (!nrst)
        !s_r.enable |=> $stable(s_r.shift)) else $error("shift while disabled");
    valid_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
        (!s_r.enable && !rd_data_hit) |=> $stable(s_r.valid)) else $error("valid moved while disabled");
    low_power_a: assert property (@(posedge mclk) disable iff (!nrst)
        (s_r.st != ST_FILL) |-> !nz.run) else $error("source running while idle");
    present_rd_a: assert property (@(posedge mclk) disable iff (!nrst)
        (rd && addr == `GEN_HW_STATUS_OFS) |=> rdata == {1'b0, present, 5'h00, $past(s_r.enable)})
        else $error("hw status readback wrong");
    enable_wr_a: assert property (@(posedge mclk) disable iff (!nrst)
        (wr && addr == `GEN_HW_STATUS_OFS) |=> s_r.enable == $past(wdata[0])) else $error("enable not written");
    vstat_rd_a: assert property (@(posedge mclk) disable iff (!nrst)
        (rd && addr == `VALID_STATUS_OFS) |=> rdata[7:1] == 7'h00) else $error("reserved valid bits set");
    // software may abandon a byte by disabling, so that cancels the deadline
    byte_fill_a: assert property (@(posedge mclk) disable iff (!nrst || !s_r.enable)
        (s_r.st == ST_FILL && s_r.enable && s_r.cnt == 3'h0 && !s_r.valid) |-> ##[1:40] s_r.valid)
        else $error("byte not collected in time");
    irq_level_a: assert property (@(posedge mclk) disable iff (!nrst)
        (byte_done && s_r.irq_mask) |=> irq) else $error("irq not raised for unmasked byte");

    // collection path: one fresh bit per step, byte only moves when complete
    shift_step_a: assert property (@(posedge mclk) disable iff (!nrst)
        (s_r.st == ST_FILL && s_r.enable && nz.bit_valid)
        |=> s_r.shift == {$past(s_r.shift[6:0]), $past(nz.bit_val)}) else $error("bit not shifted in");
    valid_full_a: assert property (@(posedge mclk) disable iff (!nrst)
        s_r.valid == (s_r.st == ST_FULL)) else $error("valid flag and full state disagree");
    out_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
        !byte_done |=> $stable(s_r.out_byte)) else $error("data byte moved without a full byte");
    state_onehot_a: assert property (@(posedge mclk) disable iff (!nrst)
        $onehot(s_r.st)) else $error("state not one-hot");

    // register port: enable only moves on a write, reads return live state
    enable_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
        !(wr && addr == `GEN_HW_STATUS_OFS) |=> $stable(s_r.enable)) else $error("enable moved without write");
    data_rd_a: assert property (@(posedge mclk) disable iff (!nrst)
        (rd && addr == `OUTPUT_BYTE_OFS) |=> rdata == $past(s_r.out_byte)) else $error("data byte readback wrong");
    vstat_val_a: assert property (@(posedge mclk) disable iff (!nrst)
        (rd && addr == `VALID_STATUS_OFS) |=> rdata[0] == $past(s_r.valid)) else $error("valid readback wrong");
    rd_idle_a: assert property (@(posedge mclk) disable iff (!nrst)
        !rd |=> rdata == 8'h00) else $error("read data not zero between reads");

    // sticky interrupt status: set by a byte, held, cleared by writing one
    irq_set_a: assert property (@(posedge mclk) disable iff (!nrst)
        byte_done |=> s_r.irq_stat) else $error("irq status not set by byte");
    irq_sticky_a: assert property (@(posedge mclk) disable iff (!nrst)
        (s_r.irq_stat && !(wr && addr == `IRQ_STATUS_OFS && wdata[`IRQ_BYTE_BIT])) |=> s_r.irq_stat)
        else $error("irq status dropped without clear");
    irq_clear_a: assert property (@(posedge mclk) disable iff (!nrst)
        (wr && addr == `IRQ_STATUS_OFS && wdata[`IRQ_BYTE_BIT] && !byte_done) |=> !s_r.irq_stat)
        else $error("irq status not cleared");

    fill_c: cover property (@(posedge mclk) disable iff (!nrst) byte_done);
    read_c: cover property (@(posedge mclk) disable iff (!nrst) rd_data_hit && s_r.valid);
    race_c: cover property (@(posedge mclk) disable iff (!nrst) rd_data_hit && byte_done);
    irq_c: cover property (@(posedge mclk) disable iff (!nrst) irq);
    hold_c: cover property (@(posedge mclk) disable iff (!nrst) s_r.st == ST_FULL && !s_r.enable);
endmodule

// ---- test/hw_random_byte_source_tb.sv ----
`timescale 1ns/1ps
`include "rbs_map.svh"
module hw_random_byte_source_tb;
    // bench-driven register port
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [31:0] addr = 32'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic irq;
    int errors = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [7:0] v;

    always #4 mclk = ~mclk;

    hw_random_byte_source u_dut (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .irq(irq));

    task automatic conclude();
        if (errors == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // hang guard, generous against roughly 220 cycles of traffic
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 4000) begin
            errors++;
            conclude();
        end
    end

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            errors++;
        end
    endtask

    // one-cycle write strobe; strobe dropped at the edge that takes it
    task automatic wr_reg(input logic [31:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe, so sample it there
    task automatic rd_reg(input logic [31:0] a, output logic [7:0] q);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        q = rdata;
    endtask

    task automatic expect_reg(input string name, input logic [31:0] a, input logic [7:0] exp);
        rd_reg(a, v);
        check(name, exp, v);
    endtask

    // bounded poll: a byte takes about ten cycles, thirty reads is ample
    task automatic wait_valid();
        for (int n = 0; n < 30; n++) begin
            rd_reg(`VALID_STATUS_OFS, v);
            if (v === 8'h01) break;
        end
        check("output valid", 8'h01, v);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic t_reset();
        expect_reg("hw status", `GEN_HW_STATUS_OFS, 8'h40);
        expect_reg("valid status", `VALID_STATUS_OFS, 8'h00);
        expect_reg("data byte", `OUTPUT_BYTE_OFS, 8'h40);
        expect_reg("irq status", `IRQ_STATUS_OFS, 8'h00);
        expect_reg("irq mask", `IRQ_MASK_OFS, 8'h00);
        expect_reg("unmapped", 32'hFFBC0170, 8'h00);
        check("irq", 8'h00, {7'h00, irq});
    endtask

    // reserved and read-only places must ignore writes
    task automatic t_reserved();
        wr_reg(`GEN_HW_STATUS_OFS, 8'hFE);
        expect_reg("hw status", `GEN_HW_STATUS_OFS, 8'h40);
        wr_reg(`VALID_STATUS_OFS, 8'hFF);
        expect_reg("valid status", `VALID_STATUS_OFS, 8'h00);
        wr_reg(`OUTPUT_BYTE_OFS, 8'h00);
        expect_reg("data byte", `OUTPUT_BYTE_OFS, 8'h40);
        idle(20);
        expect_reg("valid idle", `VALID_STATUS_OFS, 8'h00);
    endtask

    // fill one byte, then hold it while disabled and exercise the interrupt
    task automatic t_fill_irq();
        wr_reg(`GEN_HW_STATUS_OFS, 8'h01);
        expect_reg("hw status", `GEN_HW_STATUS_OFS, 8'h41);
        wait_valid();
        expect_reg("irq status", `IRQ_STATUS_OFS, 8'h01);
        check("irq masked", 8'h00, {7'h00, irq});
        wr_reg(`IRQ_MASK_OFS, 8'h01);
        idle(2);
        check("irq", 8'h01, {7'h00, irq});
        wr_reg(`GEN_HW_STATUS_OFS, 8'h00);
        idle(20);
        expect_reg("valid held", `VALID_STATUS_OFS, 8'h01);
        rd_reg(`OUTPUT_BYTE_OFS, v);
        expect_reg("valid cleared", `VALID_STATUS_OFS, 8'h00);
        wr_reg(`IRQ_STATUS_OFS, 8'h01);
        idle(2);
        check("irq cleared", 8'h00, {7'h00, irq});
        expect_reg("irq status", `IRQ_STATUS_OFS, 8'h00);
        idle(20);
        expect_reg("valid stays low", `VALID_STATUS_OFS, 8'h00);
    endtask

    // software flow: enable, one stale data read before any byte is ready, then take three in a row
    task automatic t_stream();
        int ones;
        ones = 0;
        expect_reg("present before use", `GEN_HW_STATUS_OFS, 8'h40);
        wr_reg(`GEN_HW_STATUS_OFS, 8'h01);
        rd_reg(`OUTPUT_BYTE_OFS, v);
        for (int i = 0; i < 3; i++) begin
            wait_valid();
            rd_reg(`OUTPUT_BYTE_OFS, v);
            ones += $countones(v);
            expect_reg("valid after read", `VALID_STATUS_OFS, 8'h00);
        end
        // crude monobit screen: a stuck source gives all zeros or all ones
        check("ones spread", 8'h01, {7'h00, (ones > 0 && ones < 24)});
        wr_reg(`GEN_HW_STATUS_OFS, 8'h00);
        expect_reg("hw status", `GEN_HW_STATUS_OFS, 8'h40);
    endtask

    // data read on the very edge a byte completes, then a reset in mid-run
    task automatic t_race_reset();
        wr_reg(`IRQ_STATUS_OFS, 8'h01);
        expect_reg("irq status", `IRQ_STATUS_OFS, 8'h00);
        wr_reg(`GEN_HW_STATUS_OFS, 8'h01);
        // enable lands, one cycle to start, one idle bit, then eight bits
        idle(8);
        rd_reg(`OUTPUT_BYTE_OFS, v);
        expect_reg("valid race", `VALID_STATUS_OFS, 8'h01);
        expect_reg("irq race", `IRQ_STATUS_OFS, 8'h01);
        check("irq", 8'h01, {7'h00, irq});
        @(posedge mclk);
        nrst <= 1'b0;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        t_reset();
    endtask

    initial begin
        repeat (8) @(posedge mclk);
        nrst <= 1'b1;
        t_reset();
        t_reserved();
        t_fill_irq();
        t_stream();
        t_race_reset();
        conclude();
    end
endmodule
